// >>> verilog/uer_responder.sv
// Purpose: Endpoint mode responder of the serial_interface_engine with an AHB-Lite register file.
// Assumes: Token, data-start and host-ack events arrive as synchronous one-cycle pulses.
// Notes: Engine updates win over CPU writes in the same cycle.
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module uer_responder import uer_pkg::*; #(
  parameter int NEP = 3,
  parameter int EP_SIZE = EP_SIZE_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire uer_txn_t txn,
  input wire uer_evt_t setup_start,
  input wire uer_evt_t host_ack,
  output uer_answer_t answer,
  output logic [NEP-1:0] ep_irq
);

  localparam logic [4:0] MAX_CNT = 5'(EP_SIZE) + CRC_BYTES;

  logic [3:0] mode [NEP];
  logic stall [NEP];
  logic [3:0] cnt [NEP];
  logic dval [NEP];
  logic tog [NEP];
  logic flg_setup, flg_in, flg_out, flg_ack;
  logic lock0;
  logic ap_wr;
  logic [7:0] ap_addr;

  // Engine decisions for the addressed endpoint
  logic [1:0] e;
  logic e_ok;
  logic [3:0] cur_mode;
  logic cur_stall;
  logic pkt_corrupt;
  logic eng_hit;
  logic [3:0] next_mode;
  logic upd_tc, set_dval, clr_dval, set_in, set_out, set_ack, set_irq;
  uer_answer_t next_answer;
  uer_class_t cls;

  function automatic logic accepts_setup(input logic [3:0] m);
    case (m)
      MODE_NAK_INOUT, MODE_STATUS_OUT, MODE_STALL_INOUT, MODE_IGNORE_INOUT, MODE_STATUS_IN,
      MODE_NAK_OUT_STIN, MODE_ACK_OUT_NAK_IN, MODE_NAK_IN_STOUT, MODE_ACK_IN_STOUT:
        accepts_setup = 1'b1;
      default: accepts_setup = 1'b0;
    endcase
  endfunction : accepts_setup

  function automatic uer_class_t out_class(input logic [3:0] m, input logic st);
    case (m)
      MODE_NAK_INOUT, MODE_NAK_OUT, MODE_NAK_OUT_STIN: out_class = CL_NAK;
      MODE_STALL_INOUT, MODE_STATUS_IN: out_class = CL_STALL;
      MODE_STATUS_OUT, MODE_NAK_IN_STOUT, MODE_ACK_IN_STOUT: out_class = CL_CHECK;
      MODE_ACK_OUT: out_class = st ? CL_STALL : CL_ACK;
      MODE_ACK_OUT_NAK_IN: out_class = CL_ACK;
      default: out_class = CL_IGNORE;
    endcase
  endfunction : out_class

  function automatic uer_class_t in_class(input logic [3:0] m, input logic st);
    case (m)
      MODE_NAK_INOUT, MODE_ACK_OUT_NAK_IN, MODE_NAK_IN, MODE_NAK_IN_STOUT: in_class = CL_NAK;
      MODE_STATUS_OUT, MODE_STALL_INOUT: in_class = CL_STALL;
      MODE_STATUS_IN, MODE_NAK_OUT_STIN: in_class = CL_TX0;
      MODE_RSVD_7, MODE_ACK_IN_STOUT: in_class = CL_TXCNT;
      MODE_ACK_IN: in_class = st ? CL_STALL : CL_TXCNT;
      default: in_class = CL_IGNORE;
    endcase
  endfunction : in_class

  function automatic logic is_ep_reg(input logic [7:0] a);
    is_ep_reg = (a < OFS_IRQ) && (a[1:0] == 2'b00);
  endfunction : is_ep_reg

  always_comb begin
    e = txn.valid ? txn.ep : host_ack.ep;
    e_ok = 32'(e) < NEP;
    cur_mode = MODE_DISABLE;
    cur_stall = 1'b0;
    if (e_ok) begin
      cur_mode = mode[e];
      cur_stall = stall[e];
    end
    pkt_corrupt = !txn.crc_ok || (txn.count > MAX_CNT);
    eng_hit = 1'b0;
    next_mode = cur_mode;
    upd_tc = 1'b0;
    set_dval = 1'b0;
    clr_dval = 1'b0;
    set_in = 1'b0;
    set_out = 1'b0;
    set_ack = 1'b0;
    set_irq = 1'b0;
    cls = CL_IGNORE;
    next_answer = '{valid: 1'b0, code: RSP_NONE, ep: e, len: 4'h0};
    // Disabled endpoints and failed transactions are left alone
    if (txn.valid && e_ok && cur_mode != MODE_DISABLE && txn.err_ok) begin
      eng_hit = 1'b1;
      case (txn.pid)
        PID_SETUP: begin
          if (accepts_setup(cur_mode)) begin
            upd_tc = 1'b1;
            set_irq = 1'b1;
            if (!pkt_corrupt) begin
              set_dval = 1'b1;
              set_ack = 1'b1;
              next_mode = MODE_NAK_INOUT;
              next_answer.valid = 1'b1;
              next_answer.code = RSP_ACK;
            end else if (!txn.crc_ok) begin
              clr_dval = 1'b1;
            end
          end
        end
        PID_OUT: begin
          cls = out_class(cur_mode, cur_stall);
          if (pkt_corrupt) begin
            if (cls == CL_ACK) begin
              upd_tc = 1'b1;
              set_out = 1'b1;
              set_irq = 1'b1;
              clr_dval = !txn.crc_ok;
            end
          end else begin
            case (cls)
              CL_NAK, CL_STALL: begin
                set_out = 1'b1;
                set_irq = 1'b1;
                next_answer.valid = 1'b1;
                next_answer.code = (cls == CL_NAK) ? RSP_NAK : RSP_STALL;
              end
              CL_CHECK: begin
                upd_tc = 1'b1;
                set_dval = 1'b1;
                set_out = 1'b1;
                set_irq = 1'b1;
                next_answer.valid = 1'b1;
                if (txn.count == STATUS_LEN && txn.toggle) begin
                  set_ack = 1'b1;
                  next_answer.code = RSP_ACK;
                  if (cur_mode == MODE_ACK_IN_STOUT) begin
                    next_mode = MODE_NAK_IN_STOUT;
                  end
                end else begin
                  next_answer.code = RSP_STALL;
                end
              end
              CL_ACK: begin
                upd_tc = 1'b1;
                set_dval = 1'b1;
                set_out = 1'b1;
                set_ack = 1'b1;
                set_irq = 1'b1;
                next_answer.valid = 1'b1;
                next_answer.code = RSP_ACK;
                next_mode = (cur_mode == MODE_ACK_OUT) ? MODE_NAK_OUT : MODE_NAK_INOUT;
              end
              default: ;
            endcase
          end
        end
        PID_IN: begin
          cls = in_class(cur_mode, cur_stall);
          case (cls)
            CL_NAK, CL_STALL: begin
              set_in = 1'b1;
              set_irq = 1'b1;
              next_answer.valid = 1'b1;
              next_answer.code = (cls == CL_NAK) ? RSP_NAK : RSP_STALL;
            end
            CL_TX0: begin
              next_answer.valid = 1'b1;
              next_answer.code = RSP_DATA;
            end
            CL_TXCNT: begin
              next_answer.valid = 1'b1;
              next_answer.code = RSP_DATA;
              next_answer.len = cnt[e];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end else if (!txn.valid && host_ack.valid && e_ok && cur_mode != MODE_DISABLE) begin
      // Host acknowledged our data packet: the IN transaction ends here
      eng_hit = 1'b1;
      set_in = 1'b1;
      set_ack = 1'b1;
      set_irq = 1'b1;
      if (cur_mode == MODE_ACK_IN) begin
        next_mode = MODE_NAK_IN;
      end
    end
  end

  // AHB-Lite address phase decode
  logic ap_take;
  logic rd_take;
  logic [NEP-1:0] cpu_mode_wr, cpu_cnt_wr;
  logic cpu_irq_wr;
  logic [1:0] wr_ep;
  logic unlock_rd;

  assign ap_take = hsel && htrans[1] && hready;
  assign rd_take = ap_take && !hwrite;
  assign wr_ep = ap_addr[EP_SEL_LSB +: 2];
  assign cpu_irq_wr = ap_wr && (ap_addr == OFS_IRQ);
  assign unlock_rd = rd_take && is_ep_reg(haddr[7:0]) && (haddr[EP_SEL_LSB +: 2] == 2'b00);

  always_comb begin
    cpu_mode_wr = '0;
    cpu_cnt_wr = '0;
    for (int i = 0; i < NEP; i++) begin
      if (ap_wr && is_ep_reg(ap_addr) && 32'(wr_ep) == i && !(i == 0 && lock0)) begin
        cpu_mode_wr[i] = !ap_addr[CNT_SEL_BIT];
        cpu_cnt_wr[i] = ap_addr[CNT_SEL_BIT];
      end
    end
  end

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [1:0] ep;
    rd_word = 32'h0;
    ep = a[EP_SEL_LSB +: 2];
    if (is_ep_reg(a) && 32'(ep) < NEP) begin
      if (a[CNT_SEL_BIT]) begin
        rd_word[CNT_LSB +: 4] = cnt[ep];
        rd_word[DVAL_BIT] = dval[ep];
        rd_word[TOG_BIT] = tog[ep];
      end else begin
        rd_word[MODE_LSB +: 4] = mode[ep];
        if (ep == 2'b00) begin
          rd_word[FLG_ACK_BIT] = flg_ack;
          rd_word[FLG_OUT_BIT] = flg_out;
          rd_word[FLG_IN_BIT] = flg_in;
          rd_word[FLG_SETUP_BIT] = flg_setup;
        end else begin
          rd_word[STALL_BIT] = stall[ep];
        end
      end
    end else if (a == OFS_IRQ) begin
      rd_word[NEP-1:0] = ep_irq;
    end
  endfunction : rd_word

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_wr <= ap_take && hwrite;
      if (ap_take) begin
        ap_addr <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata <= rd_word(haddr[7:0]);
      end
    end
  end

  // Mode and stall select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NEP; i++) begin
        mode[i] <= RST_MODE;
        stall[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NEP; i++) begin
        if (eng_hit && 32'(e) == i) begin
          mode[i] <= next_mode;
        end else if (cpu_mode_wr[i]) begin
          mode[i] <= hwdata[MODE_LSB +: 4];
          stall[i] <= (i != 0) && hwdata[STALL_BIT];
        end
      end
    end
  end

  // Count, data-valid and data_toggle_flag per endpoint
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NEP; i++) begin
        cnt[i] <= RST_CNT;
        dval[i] <= 1'b0;
        tog[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NEP; i++) begin
        if (eng_hit && 32'(e) == i && (upd_tc || set_dval || clr_dval)) begin
          if (upd_tc) begin
            cnt[i] <= 4'(txn.count - CRC_BYTES);
            tog[i] <= txn.toggle;
          end
          if (set_dval) begin
            dval[i] <= 1'b1;
          end else if (clr_dval) begin
            dval[i] <= 1'b0;
          end
        end else if (cpu_cnt_wr[i]) begin
          cnt[i] <= hwdata[CNT_LSB +: 4];
          dval[i] <= hwdata[DVAL_BIT];
          tog[i] <= hwdata[TOG_BIT];
        end
      end
    end
  end

  // SETUP data phase seen on the control endpoint; beats a same-cycle firmware write
  logic setup_seen;
  assign setup_seen = setup_start.valid && setup_start.ep == 2'b00 && accepts_setup(mode[0]);

  // Control endpoint token-type and ACK flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flg_setup <= 1'b0;
      flg_in <= 1'b0;
      flg_out <= 1'b0;
      flg_ack <= 1'b0;
    end else if (cpu_mode_wr[0] && !(eng_hit && e == 2'b00)) begin
      flg_setup <= hwdata[FLG_SETUP_BIT] || setup_seen;
      flg_in <= hwdata[FLG_IN_BIT];
      flg_out <= hwdata[FLG_OUT_BIT];
      flg_ack <= hwdata[FLG_ACK_BIT];
    end else begin
      if (setup_seen) begin
        flg_setup <= 1'b1;
      end
      if (eng_hit && e == 2'b00) begin
        flg_in <= flg_in | set_in;
        flg_out <= flg_out | set_out;
        flg_ack <= flg_ack | set_ack;
      end
    end
  end

  // Interrupts: set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep_irq <= '0;
    end else begin
      for (int i = 0; i < NEP; i++) begin
        if (eng_hit && set_irq && 32'(e) == i) begin
          ep_irq[i] <= 1'b1;
        end else if (cpu_irq_wr && hwdata[i]) begin
          ep_irq[i] <= 1'b0;
        end
      end
    end
  end

  // Endpoint 0 write interlock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock0 <= 1'b0;
    end else if (eng_hit && set_ack && e == 2'b00) begin
      lock0 <= 1'b1;
    end else if (unlock_rd) begin
      lock0 <= 1'b0;
    end
  end

  // Answer to the packet engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      answer <= '{valid: 1'b0, code: RSP_NONE, ep: 2'b00, len: 4'h0};
    end else begin
      answer <= next_answer;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_disabled_stays;
    (mode[0] == MODE_DISABLE && !cpu_mode_wr[0]) |=> (mode[0] == MODE_DISABLE);
  endproperty
  a_disabled_stays: assert property (p_disabled_stays) else $error("disabled mode left");

  property p_setup_ack;
    (txn.valid && txn.pid == PID_SETUP && txn.ep == 2'b00 && txn.err_ok && txn.crc_ok &&
     txn.count <= MAX_CNT && accepts_setup(mode[0]))
    |=> (mode[0] == MODE_NAK_INOUT && answer.valid && answer.code == RSP_ACK && ep_irq[0]
         && dval[0]);
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");

  property p_status_out_ack;
    (txn.valid && txn.pid == PID_OUT && txn.ep == 2'b00 && txn.err_ok && txn.crc_ok &&
     txn.count == STATUS_LEN && txn.toggle && mode[0] == MODE_ACK_IN_STOUT)
    |=> (mode[0] == MODE_NAK_IN_STOUT && answer.code == RSP_ACK && lock0);
  endproperty
  a_status_out_ack: assert property (p_status_out_ack) else $error("status out wrong");

  property p_check_stall;
    (txn.valid && txn.pid == PID_OUT && out_class(cur_mode, cur_stall) == CL_CHECK &&
     !pkt_corrupt && txn.err_ok && (txn.count != STATUS_LEN || !txn.toggle))
    |=> (answer.valid && answer.code == RSP_STALL);
  endproperty
  a_check_stall: assert property (p_check_stall) else $error("bad status out acked");

  property p_in_ignored;
    (txn.valid && txn.pid == PID_IN && txn.ep == 2'b01 && mode[1] == MODE_NAK_OUT)
    |=> (!answer.valid && $stable(ep_irq[1]));
  endproperty
  a_in_ignored: assert property (p_in_ignored) else $error("IN answered on OUT ep");

  property p_tx_count;
    (txn.valid && txn.pid == PID_IN && txn.ep == 2'b01 && txn.err_ok &&
     mode[1] == MODE_ACK_IN && !stall[1])
    |=> (answer.code == RSP_DATA && answer.len == $past(cnt[1]));
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("tx count wrong");

  property p_tx_zero;
    (txn.valid && txn.pid == PID_IN && txn.ep == 2'b00 && txn.err_ok &&
     mode[0] == MODE_STATUS_IN) |=> (answer.code == RSP_DATA && answer.len == 4'h0);
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("zero length reply wrong");

  property p_lock_holds;
    (lock0 && ap_wr && ap_addr == 8'h00 && !eng_hit) |=> $stable(mode[0]);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked mode written");

  property p_invalid_silent;
    (txn.valid && !txn.err_ok) |=> (!answer.valid ##1 !answer.valid);
  endproperty
  a_invalid_silent: assert property (p_invalid_silent) else $error("invalid answered");

  property p_in_ack_advance;
    (!txn.valid && host_ack.valid && host_ack.ep == 2'b01 && mode[1] == MODE_ACK_IN)
    |=> (mode[1] == MODE_NAK_IN && ep_irq[1]);
  endproperty
  a_in_ack_advance: assert property (p_in_ack_advance) else $error("IN ack no advance");

  c_setup: cover property (answer.valid && answer.code == RSP_ACK && mode[0] == MODE_NAK_INOUT);
  c_data: cover property (answer.valid && answer.code == RSP_DATA);
  c_unlock: cover property (lock0 ##1 !lock0);

endmodule : uer_responder

// >>> verilog/uer_pkg.sv
// Purpose: Shared constants and carriers for the USB endpoint mode responder.
// Assumes: Register words are 32 bits; only the low byte of each register is used.
// Notes: Endpoint n mode register at n*8, count register at n*8+4, interrupt at 0x18.
package uer_pkg;

  // Endpoint mode encodings
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
  localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MODE_RSVD_5 = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_RSVD_7 = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
  localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hb;
  localparam logic [3:0] MODE_NAK_IN = 4'hc;
  localparam logic [3:0] MODE_ACK_IN = 4'hd;
  localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
  localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;

  // Register map
  localparam logic [7:0] OFS_IRQ = 8'h18;
  localparam int EP_SEL_LSB = 3;
  localparam int CNT_SEL_BIT = 2;

  // Field positions
  localparam int MODE_LSB = 0;
  localparam int FLG_ACK_BIT = 4;
  localparam int FLG_OUT_BIT = 5;
  localparam int FLG_IN_BIT = 6;
  localparam int FLG_SETUP_BIT = 7;
  localparam int STALL_BIT = 7;
  localparam int CNT_LSB = 0;
  localparam int DVAL_BIT = 6;
  localparam int TOG_BIT = 7;

  // Reset values and packet figures
  localparam logic [3:0] RST_MODE = MODE_DISABLE;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam logic [4:0] STATUS_LEN = 5'h02;
  localparam int EP_SIZE_DEF = 8;

  typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT, PID_NONE} uer_pid_t;
  typedef enum logic [2:0] {RSP_NONE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA} uer_rsp_t;
  typedef enum logic [2:0] {CL_IGNORE, CL_ACK, CL_NAK, CL_STALL, CL_CHECK, CL_TX0,
                            CL_TXCNT} uer_class_t;

  // End of a received token/data exchange, one-cycle valid
  typedef struct packed {
    logic valid;
    uer_pid_t pid;
    logic [1:0] ep;
    logic [4:0] count;
    logic crc_ok;
    logic err_ok;
    logic toggle;
  } uer_txn_t;

  // Endpoint-tagged one-cycle event
  typedef struct packed {
    logic valid;
    logic [1:0] ep;
  } uer_evt_t;

  // Answer to the packet engine, one-cycle valid
  typedef struct packed {
    logic valid;
    uer_rsp_t code;
    logic [1:0] ep;
    logic [3:0] len;
  } uer_answer_t;

endpackage : uer_pkg

// >>> sim/uer_host_model.sv
// Purpose: Host side token source for the endpoint responder.
// Assumes: One token in flight; data answers are acknowledged after ack_delay cycles.
// Notes: Idle token fields carry inverted junk, never stale values.
`timescale 1ns/100ps
module uer_host_model import uer_pkg::*; (
  input wire logic hclk,
  input wire uer_answer_t answer,
  output uer_txn_t txn,
  output uer_evt_t setup_start,
  output uer_evt_t host_ack
);
  int ack_delay = 1;
  int ack_cnt = 0;
  int n_ans = 0;
  uer_answer_t last = '0;
  initial begin
    txn = '0;
    setup_start = '0;
    host_ack = '0;
  end
  task send(input uer_pid_t pid, input logic [1:0] ep, input logic [4:0] cnt,
            input logic tog, input logic crc, input logic err);
    if (pid == PID_SETUP) begin
      setup_start <= '{1'b1, ep};
      @(posedge hclk);
      setup_start <= '0;
    end
    txn <= '{1'b1, pid, ep, cnt, crc, err, tog};
    @(posedge hclk);
    txn <= {1'b0, ~txn[$bits(uer_txn_t)-2:0]};
  endtask : send
  // Data answers are acknowledged later, promptly or slowly
  always @(posedge hclk) begin
    host_ack <= '0;
    if (answer.valid === 1'b1) begin
      last <= answer;
      n_ans <= n_ans + 1;
      if (answer.code == RSP_DATA) ack_cnt <= ack_delay;
    end else if (ack_cnt > 0) begin
      ack_cnt <= ack_cnt - 1;
      if (ack_cnt == 1) host_ack <= '{1'b1, last.ep};
    end
  end
endmodule : uer_host_model

// >>> sim/tb.sv
// Purpose: Self-checking bench for the endpoint mode responder.
// Assumes: One AHB-Lite master and one slave; a token is answered within a few cycles.
// Notes: Random modes on endpoint 2 are checked against a response table.
`timescale 1ns/100ps
module tb import uer_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, rd, seed = 32'h25;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  wire logic hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0] ep_irq;
  wire uer_txn_t txn;
  wire uer_evt_t setup_start, host_ack;
  wire uer_answer_t answer;
  int bad_count = 0, n_checks = 0;
  uer_responder #(.NEP(3), .EP_SIZE(EP_SIZE_DEF)) uer_responder_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .txn(txn), .setup_start(setup_start), .host_ack(host_ack),
    .answer(answer), .ep_irq(ep_irq));
  uer_host_model uer_host_model_i (.hclk(hclk), .answer(answer), .txn(txn),
    .setup_start(setup_start), .host_ack(host_ack));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      final_report();
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(nm, rd & msk, e);
    chk("hresp", 32'(hresp), 32'h0);
    if (a == OFS_IRQ) chk("irq pin", 32'(ep_irq), e);
  endtask : rdchk
  task tok(input uer_pid_t pid, input logic [1:0] ep, input logic [4:0] cnt, input logic tog,
           input logic crc, input logic err, input uer_rsp_t code, input logic [3:0] len);
    int n0;
    uer_answer_t a;
    n0 = uer_host_model_i.n_ans;
    uer_host_model_i.send(pid, ep, cnt, tog, crc, err);
    repeat (8) @(posedge hclk);
    a = uer_host_model_i.last;
    chk("answer count", 32'(uer_host_model_i.n_ans - n0), 32'(code != RSP_NONE));
    if (code != RSP_NONE) chk("answer", {a.code, a.ep}, {code, ep});
    if (code == RSP_DATA) chk("answer len", a.len, len);
  endtask : tok
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One nibble per mode, mode 15 leftmost
  function automatic uer_rsp_t exp_code(input logic [3:0] m, input uer_pid_t p);
    logic [63:0] t;
    t = (p == PID_IN) ? 64'h4242240044003320 : (p == PID_OUT) ? 64'h1100121203003120 :
        64'h1100110001011110;
    return uer_rsp_t'(3'(t >> (m * 4)));
  endfunction : exp_code
  // Zero-length reply modes send an empty packet whatever the count holds
  function automatic logic [3:0] exp_len(input logic [3:0] m, input logic [3:0] c);
    return (m == MODE_STATUS_IN || m == MODE_NAK_OUT_STIN) ? 4'h0 : c;
  endfunction : exp_len
  initial begin
    forever #5 hclk = ~hclk;
  end
  initial begin
    logic [3:0] m, c;
    uer_pid_t p;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ep0 mode", 8'h00, 32'hffffffff, 32'h0);
    rdchk("irq", 8'h18, 32'hffffffff, 32'h0);
    rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    tok(PID_OUT, 2'h1, 5'h02, 1'b1, 1'b1, 1'b1, RSP_NONE, 4'h0);
    bus(1'b1, 8'h00, {28'h0, MODE_STATUS_OUT});
    tok(PID_SETUP, 2'h0, 5'h0a, 1'b0, 1'b1, 1'b1, RSP_ACK, 4'h0);
    rdchk("irq", 8'h18, 32'h7, 32'h1);
    bus(1'b1, 8'h00, 32'h0f);
    rdchk("ep0 mode", 8'h00, 32'hff, 32'h91);
    bus(1'b1, 8'h18, 32'h1);
    rdchk("irq", 8'h18, 32'h7, 32'h0);
    bus(1'b1, 8'h00, {28'h0, MODE_ACK_IN_STOUT});
    rdchk("ep0 mode", 8'h00, 32'hf, 32'hf);
    tok(PID_OUT, 2'h0, 5'h02, 1'b1, 1'b1, 1'b1, RSP_ACK, 4'h0);
    rdchk("ep0 mode", 8'h00, 32'hf, 32'he);
    tok(PID_OUT, 2'h0, 5'h02, 1'b0, 1'b1, 1'b1, RSP_STALL, 4'h0);
    tok(PID_OUT, 2'h0, 5'h04, 1'b1, 1'b1, 1'b1, RSP_STALL, 4'h0);
    bus(1'b1, 8'h00, {28'h0, MODE_STATUS_IN});
    tok(PID_IN, 2'h0, 5'h00, 1'b0, 1'b1, 1'b1, RSP_DATA, 4'h0);
    rdchk("ep0 mode", 8'h00, 32'h4f, 32'h46);
    tok(PID_IN, 2'h0, 5'h00, 1'b0, 1'b1, 1'b0, RSP_NONE, 4'h0);
    bus(1'b1, 8'h18, 32'h7);
    tok(PID_SETUP, 2'h0, 5'h0a, 1'b0, 1'b0, 1'b1, RSP_NONE, 4'h0);
    rdchk("irq", 8'h18, 32'h7, 32'h1);
    tok(PID_SETUP, 2'h0, 5'h0c, 1'b0, 1'b1, 1'b1, RSP_NONE, 4'h0);
    rdchk("ep0 mode", 8'h00, 32'hf, 32'h6);
    bus(1'b1, 8'h0c, 32'h5);
    bus(1'b1, 8'h08, {28'h0, MODE_ACK_IN});
    uer_host_model_i.ack_delay = 4;
    tok(PID_IN, 2'h1, 5'h00, 1'b0, 1'b1, 1'b1, RSP_DATA, 4'h5);
    rdchk("ep1 mode", 8'h08, 32'hf, 32'hc);
    tok(PID_OUT, 2'h1, 5'h02, 1'b1, 1'b1, 1'b1, RSP_NONE, 4'h0);
    bus(1'b1, 8'h08, {28'h0, MODE_ACK_OUT_NAK_IN});
    tok(PID_OUT, 2'h1, 5'h06, 1'b0, 1'b1, 1'b1, RSP_ACK, 4'h0);
    tok(PID_OUT, 2'h1, 5'h06, 1'b1, 1'b1, 1'b1, RSP_NAK, 4'h0);
    bus(1'b1, 8'h08, 32'h89);
    tok(PID_OUT, 2'h1, 5'h06, 1'b0, 1'b1, 1'b1, RSP_STALL, 4'h0);
    bus(1'b1, 8'h08, 32'h09);
    tok(PID_OUT, 2'h1, 5'h06, 1'b0, 1'b1, 1'b1, RSP_ACK, 4'h0);
    rdchk("ep1 mode", 8'h08, 32'hf, 32'h8);
    tok(PID_IN, 2'h1, 5'h00, 1'b0, 1'b1, 1'b1, RSP_NONE, 4'h0);
    for (int i = 0; i < 40; i++) begin
      m = 4'(rnd());
      p = uer_pid_t'(rnd() % 3);
      c = 4'(rnd() % 9);
      uer_host_model_i.ack_delay = (i % 2) ? 1 : 4;
      bus(1'b1, 8'h10, {28'h0, m});
      bus(1'b1, 8'h14, {28'h0, c});
      tok(p, 2'h2, (p == PID_SETUP) ? 5'h0a : 5'h02, 1'b1, 1'b1, 1'b1, exp_code(m, p),
          exp_len(m, c));
    end
    final_report();
  end
endmodule : tb
